//--- design/mdrop_pkg.sv
/*
  Shared constants, types and helper functions for the multidrop command
  addressing block: character codes, address ranges, command codes,
  reply header sets, parser states and the decoded command carrier.
  Assumes characters arrive as 8-bit codes from a UART on the same clock.
*/
package mdrop_pkg;

  // framing and header characters
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_TILDE = 8'h7e;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_EQ = 8'h3d;
  // non-printing command headers used with the alternate header setting
  localparam logic [7:0] ALT_STAR = 8'h01;
  localparam logic [7:0] ALT_TILDE = 8'h02;

  // reply headers: printable set and alternate set
  localparam logic [7:0] RH_ASCII_ASSIGNED = 8'h23;
  localparam logic [7:0] RH_ASCII_NULL = 8'h3f;
  localparam logic [31:0] RH_BIN_NULL_SET = {8'h25, 8'h7c, 8'h26, 8'h5e};
  localparam logic [31:0] RH_BIN_ASSIGNED_SET = {8'h5c, 8'h7b, 8'h7d, 8'h40};
  localparam logic [7:0] ALT_RH_ASCII_ASSIGNED = 8'h03;
  localparam logic [7:0] ALT_RH_ASCII_NULL = 8'h04;
  localparam logic [7:0] ALT_RH_BIN_ASSIGNED = 8'h10;
  localparam logic [7:0] ALT_RH_BIN_NULL = 8'h14;

  // addresses, two bcd digits
  localparam logic [7:0] ADDR_NULL = 8'h00;
  localparam logic [7:0] ID_MAX = 8'h89;
  localparam logic [7:0] GROUP_MIN = 8'h90;
  localparam logic [7:0] GROUP_MAX = 8'h98;
  localparam logic [7:0] ADDR_GLOBAL = 8'h99;
  localparam logic [7:0] GROUP_RESET = 8'h90;
  localparam logic [7:0] SUB_RESET = 8'h00;
  localparam logic [7:0] SUB_MAX = 8'h89;

  // command codes, upper-case letter then a second character, second zero for one letter
  localparam logic [15:0] CODE_WRITE_ENABLE = 16'h5745;
  localparam logic [15:0] CODE_ADDRESS_ASSIGN = 16'h4944;
  localparam logic [15:0] CODE_SERIAL = 16'h5300;
  localparam logic [15:0] CODE_INIT = 16'h494e;
  localparam logic [15:0] CODE_PRESS_BIN_ONCE = 16'h5033;
  localparam logic [15:0] CODE_CONT_PRESS_BIN = 16'h5034;

  // value digit counts
  localparam logic [3:0] DIGITS_SERIAL = 4'h8;
  localparam logic [3:0] DIGITS_ID = 4'h2;
  localparam logic [3:0] DIGITS_GROUP_ID = 4'h4;
  localparam logic [3:0] DIGITS_MAX = 4'h8;

  localparam int TURN_CNT_W = 8;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_ADDR_HI = 3'b001,
    P_ADDR_LO = 3'b010,
    P_CODE = 3'b011,
    P_VALUE = 3'b100
  } parse_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] code;
    logic is_read;
    logic binary;
    logic write_enabled;
    logic [3:0] ndig;
    logic [31:0] value;
  } cmd_type;

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    to_upper = (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
  endfunction

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= 8'h30) && (c <= 8'h39);
  endfunction

  function automatic logic [6:0] bcd2bin(input logic [7:0] b);
    bcd2bin = ({3'h0, b[7:4]} * 7'h0a) + {3'h0, b[3:0]};
  endfunction

  function automatic logic [7:0] reply_header(input logic alt, input logic nul,
                                              input logic bin, input logic [1:0] kind);
    logic [31:0] set;
    set = nul ? RH_BIN_NULL_SET : RH_BIN_ASSIGNED_SET;
    if (!bin)
      reply_header = alt ? (nul ? ALT_RH_ASCII_NULL : ALT_RH_ASCII_ASSIGNED)
                         : (nul ? RH_ASCII_NULL : RH_ASCII_ASSIGNED);
    else if (alt)
      reply_header = (nul ? ALT_RH_BIN_NULL : ALT_RH_BIN_ASSIGNED) + {6'h00, kind};
    else
      reply_header = set[kind*8 +: 8];
  endfunction

endpackage

//--- design/char_fold.sv
/*
  Registers each received character, folds lower case to upper case and
  classifies headers, carriage return and digits in one clock.
  Assumes rx characters are already in the clk domain.
*/
`timescale 1ns/1ps
module char_fold
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [7:0] in_char,
  input wire logic alt_sel,
  output logic out_valid,
  output logic [7:0] out_char,
  output logic hdr_star,
  output logic hdr_tilde,
  output logic is_dollar,
  output logic is_cr,
  output logic is_num
);

  logic [7:0] up;
  assign up = mdrop_pkg::to_upper(in_char);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_char <= 8'h00;
      hdr_star <= 1'b0;
      hdr_tilde <= 1'b0;
      is_dollar <= 1'b0;
      is_cr <= 1'b0;
      is_num <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      out_char <= up;
      // header set follows the alternate setting
      hdr_star <= in_valid && (in_char == (alt_sel ? mdrop_pkg::ALT_STAR : mdrop_pkg::CH_STAR));
      hdr_tilde <= in_valid
                   && (in_char == (alt_sel ? mdrop_pkg::ALT_TILDE : mdrop_pkg::CH_TILDE));
      is_dollar <= in_valid && (in_char == mdrop_pkg::CH_DOLLAR);
      is_cr <= in_valid && (in_char == mdrop_pkg::CH_CR);
      is_num <= in_valid && mdrop_pkg::is_digit(in_char);
    end
  end

endmodule

//--- design/turn_gate.sv
/*
  Waits for this unit's turn in a reply sequence by counting carriage
  returns seen on the bus after the command. Position 1 is first.
  Assumes arm and abort are single-cycle pulses on clk.
*/
`timescale 1ns/1ps
module turn_gate
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic [6:0] position,
  input wire logic prompted,
  input wire logic cr_seen,
  input wire logic abort,
  output logic go
);

  logic armed_r;
  logic [mdrop_pkg::TURN_CNT_W-1:0] cnt_r;
  logic [mdrop_pkg::TURN_CNT_W-1:0] target_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      armed_r <= 1'b0;
      cnt_r <= '0;
      target_r <= '0;
      go <= 1'b0;
    end
    else
    begin
      go <= 1'b0;
      if (arm)
      begin
        armed_r <= 1'b1;
        cnt_r <= '0;
        // prompted: a host cr before each reply, plus each earlier reply's cr
        target_r <= prompted ? 8'({position, 1'b0} - 8'h01) : 8'({1'b0, position} - 8'h01);
      end
      else if (abort)
        armed_r <= 1'b0;
      else if (armed_r && cnt_r == target_r)
      begin
        go <= 1'b1;
        armed_r <= 1'b0;
      end
      else if (armed_r && cr_seen)
        cnt_r <= cnt_r + 8'h01;
    end
  end

endmodule

//--- design/multidrop_command_addressing.sv
/*
  Command interpreter and reply sequencer for a networked sensor unit.
  Parses framed host commands, matches unit, group and global addresses,
  keeps the unit address, group and sub-address, and decides when this
  unit may start its reply on a shared multidrop bus or a ring.
  Assumes a UART delivers rx characters on clk and a reply transmitter
  starts on reply_go using reply_hdr and reply_addr.
*/
// How it works
// R1: unassigned multidrop unit answers only null-address commands, header then digits 00
// R2: unassigned unit acts on group and global commands, never replies to global; on the ring the code replies to global directly
// R3: group or global replies wait until the next lower position finished
// R4: global replies follow ascending unit identifier
// R5: group replies follow ascending sub-address
// R6: a missing position stops the chain; the command is complete
// R7: sub-addresses start at 01; group and sub-address written as four digits
// R8: chained option: global replies back to back starting at identifier 01
// R9: host stays silent until the last chained reply ends
// R10: a carriage return during a chain starts the next unit's reply
// R11: prompted option: each reply needs previous end plus a fresh carriage return
// R12: alternate setting uses non-printing headers for commands and replies
// R13: commands open with asterisk or tilde header and close with carriage return
// R14: replies open with one of ten headers, two printable, eight binary
// R15: address is two decimal digits then a one or two character code
// R16: letters of either case are folded to upper case before decoding
// R17: on the ring a dollar sign suspends continuous output while typing
// R18: on the ring an erroneous command is sent back unchanged
// R19: on the ring group and global commands are always passed back
// R20: execute on carriage return; a new header restarts parsing
// R21: only the leading characters needed are decoded, the rest ignored; the code flags a third code character as an error instead
// R22: a value above range is stored as the range maximum
// R23: a command without a value part, or letter plus bare equals, is a read
// R24: after a matching serial command, take the next global identifier
// R25: identifiers 01 to 89, groups 90 to 98, global 99, null at power-up
// R26: group address resets to 90
// R27: parameter changes need a preceding write enable, except initialization
// R28: commands for other addresses are ignored without a reply
`timescale 1ns/1ps
module multidrop_command_addressing
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic ring_mode,
  input wire logic chained_reply_option,
  input wire logic prompted_reply_option,
  input wire logic alternate_header_select,
  input wire logic [31:0] serial_bcd,
  input wire logic [1:0] binary_kind,
  output logic cmd_valid,
  output mdrop_pkg::cmd_type cmd,
  output logic reply_go,
  output logic [7:0] reply_hdr,
  output logic [7:0] reply_addr,
  output logic [15:0] group_sub,
  output logic suspend,
  output logic echo_req
);

  logic [7:0] f_char;
  logic f_valid, f_star, f_tilde, f_dollar, f_cr, f_num;
  char_fold u_fold
  (
    .clk(clk), .rst_n(rst_n), .in_valid(rx_valid), .in_char(rx_char),
    .alt_sel(alternate_header_select), .out_valid(f_valid), .out_char(f_char),
    .hdr_star(f_star), .hdr_tilde(f_tilde), .is_dollar(f_dollar), .is_cr(f_cr),
    .is_num(f_num)
  );

  mdrop_pkg::parse_state_type state_r;
  mdrop_pkg::cmd_type work_r;
  logic [1:0] code_len_r;
  logic [6:0] pos_r;
  logic [7:0] own_id_r, group_r, sub_r;
  logic err_r, eq_seen_r, we_armed_r, serial_hit_r, arm_r, direct_go_r, gate_go;
  // one-cycle decode of the finished command
  logic exec, is_global, is_group, accept, is_read, wr_ok, nul;
  assign exec = f_cr && state_r != mdrop_pkg::P_IDLE; // [R20]
  assign is_global = work_r.addr == mdrop_pkg::ADDR_GLOBAL;
  assign is_group = work_r.addr >= mdrop_pkg::GROUP_MIN && work_r.addr <= mdrop_pkg::GROUP_MAX;
  // null address matches only while own id is still null [R1] [R28]
  assign accept = !err_r && (work_r.addr == own_id_r || is_global
                  || (is_group && work_r.addr == group_r)); // [R2]
  // no value, or one letter with a bare equals, reads the parameter [R23]
  assign is_read = !eq_seen_r || (work_r.ndig == 4'h0 && work_r.code[7:0] == 8'h00);
  assign wr_ok = we_armed_r || work_r.code == mdrop_pkg::CODE_INIT; // [R27]
  assign nul = own_id_r == mdrop_pkg::ADDR_NULL;

  // parser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= mdrop_pkg::P_IDLE;
      work_r <= '0;
      err_r <= 1'b0;
      code_len_r <= 2'h0;
      eq_seen_r <= 1'b0;
    end
    else if (f_star || f_tilde)
    begin
      // a new header drops any partial command [R13] [R20]
      state_r <= mdrop_pkg::P_ADDR_HI;
      work_r <= '0;
      work_r.binary <= f_tilde;
      err_r <= 1'b0;
      code_len_r <= 2'h0;
      eq_seen_r <= 1'b0;
    end
    else if (f_cr)
      state_r <= mdrop_pkg::P_IDLE;
    else if (f_valid)
    begin
      case (state_r)
        mdrop_pkg::P_ADDR_HI:
        begin
          work_r.addr[7:4] <= f_char[3:0]; // [R15]
          err_r <= err_r || !f_num;
          state_r <= mdrop_pkg::P_ADDR_LO;
        end
        mdrop_pkg::P_ADDR_LO:
        begin
          work_r.addr[3:0] <= f_char[3:0]; // [R15]
          err_r <= err_r || !f_num;
          state_r <= mdrop_pkg::P_CODE;
        end
        mdrop_pkg::P_CODE:
        begin
          if (f_char == mdrop_pkg::CH_EQ)
          begin
            eq_seen_r <= 1'b1;
            err_r <= err_r || code_len_r == 2'h0;
            state_r <= mdrop_pkg::P_VALUE;
          end
          else if (code_len_r == 2'h0)
          begin
            // folded upper case letter opens the code [R16]
            work_r.code[15:8] <= f_char;
            err_r <= err_r || f_char < 8'h41 || f_char > 8'h5a;
            code_len_r <= 2'h1;
          end
          else if (code_len_r == 2'h1)
          begin
            work_r.code[7:0] <= f_char; // [R15]
            code_len_r <= 2'h2;
          end
          else
            err_r <= 1'b1;
        end
        mdrop_pkg::P_VALUE:
        begin
          // only the first eight digits count; other characters are ignored [R21]
          if (f_num && work_r.ndig < mdrop_pkg::DIGITS_MAX)
          begin
            work_r.value <= {work_r.value[27:0], f_char[3:0]};
            work_r.ndig <= work_r.ndig + 4'h1;
          end
        end
        default:
          state_r <= mdrop_pkg::P_IDLE;
      endcase
    end
  end

  // command hand-off to the executor
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmd_valid <= 1'b0;
      cmd <= '0;
    end
    else
    begin
      cmd_valid <= exec && accept;
      if (exec && accept)
      begin
        cmd <= work_r;
        cmd.is_read <= is_read;
        cmd.write_enabled <= wr_ok; // [R27]
      end
    end
  end

  // address, group and serial match state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      own_id_r <= mdrop_pkg::ADDR_NULL; // [R25]
      group_r <= mdrop_pkg::GROUP_RESET; // [R26]
      sub_r <= mdrop_pkg::SUB_RESET;
      we_armed_r <= 1'b0;
      serial_hit_r <= 1'b0;
    end
    else if (exec && accept)
    begin
      // write enable covers only the next accepted command [R27]
      we_armed_r <= work_r.code == mdrop_pkg::CODE_WRITE_ENABLE;
      if (work_r.code == mdrop_pkg::CODE_SERIAL && is_global && we_armed_r
          && work_r.ndig == mdrop_pkg::DIGITS_SERIAL && work_r.value == serial_bcd)
        serial_hit_r <= 1'b1; // [R24]
      if (work_r.code == mdrop_pkg::CODE_ADDRESS_ASSIGN && !is_read && we_armed_r
          && (!is_global || serial_hit_r)) // [R24]
      begin
        if (is_global)
          serial_hit_r <= 1'b0;
        if (work_r.ndig == mdrop_pkg::DIGITS_GROUP_ID)
        begin
          // group digits first, sub-address after [R7]
          group_r <= work_r.value[15:8] > mdrop_pkg::GROUP_MAX ? mdrop_pkg::GROUP_MAX
                     : work_r.value[15:8] < mdrop_pkg::GROUP_MIN ? mdrop_pkg::GROUP_MIN
                     : work_r.value[15:8]; // [R22]
          sub_r <= work_r.value[7:0] > mdrop_pkg::SUB_MAX ? mdrop_pkg::SUB_MAX
                   : work_r.value[7:0]; // [R22]
        end
        else if (work_r.ndig == mdrop_pkg::DIGITS_ID)
          own_id_r <= work_r.value[7:0] > mdrop_pkg::ID_MAX ? mdrop_pkg::ID_MAX
                      : work_r.value[7:0]; // [R22] [R25]
      end
    end
  end

  // reply scheduling
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      arm_r <= 1'b0;
      pos_r <= 7'h00;
      direct_go_r <= 1'b0;
    end
    else
    begin
      arm_r <= 1'b0;
      direct_go_r <= 1'b0;
      if (exec && accept && is_read)
      begin
        if (ring_mode || (!is_global && !is_group))
          direct_go_r <= 1'b1; // [R1]
        else if (is_global && !nul)
        begin
          // global order is identifier order; null units stay silent [R2] [R4] [R8]
          arm_r <= 1'b1;
          pos_r <= mdrop_pkg::bcd2bin(own_id_r);
        end
        else if (is_group && sub_r != mdrop_pkg::SUB_RESET)
        begin
          arm_r <= 1'b1;
          pos_r <= mdrop_pkg::bcd2bin(sub_r); // [R5] [R7]
        end
      end
    end
  end

  // counts bus crs; a gap stalls the chain, a silent host is assumed [R3] [R6] [R9] [R10]
  turn_gate u_turn
  (
    .clk(clk), .rst_n(rst_n), .arm(arm_r), .position(pos_r), .cr_seen(f_cr),
    .prompted(prompted_reply_option && !chained_reply_option), // [R11]
    .abort(f_star || f_tilde), .go(gate_go)
  );

  // reply start, header and ring controls
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reply_go <= 1'b0;
      reply_hdr <= mdrop_pkg::RH_ASCII_NULL;
      reply_addr <= mdrop_pkg::ADDR_NULL;
      group_sub <= {mdrop_pkg::GROUP_RESET, mdrop_pkg::SUB_RESET};
      suspend <= 1'b0;
      echo_req <= 1'b0;
    end
    else
    begin
      reply_go <= direct_go_r || gate_go;
      // one of two ascii or eight binary headers, from the non-printing alternate set when selected [R12] [R14]
      reply_hdr <= mdrop_pkg::reply_header(alternate_header_select, nul,
                   cmd.code == mdrop_pkg::CODE_PRESS_BIN_ONCE
                   || cmd.code == mdrop_pkg::CODE_CONT_PRESS_BIN, binary_kind);
      reply_addr <= own_id_r; // [R1]
      group_sub <= {group_r, sub_r};
      if (ring_mode && f_dollar && state_r == mdrop_pkg::P_IDLE)
        suspend <= 1'b1; // [R17]
      else if (f_cr || !ring_mode)
        suspend <= 1'b0;
      echo_req <= ring_mode && exec && (err_r || is_group || is_global); // [R18] [R19]
    end
  end

  a_null_no_global: assert property (@(posedge clk) disable iff (!rst_n)
    exec && accept && is_read && is_global && nul && !ring_mode |=> !reply_go [*4]) // [R2]
    else $error("null unit replied to a global command");
  a_direct_reply: assert property (@(posedge clk) disable iff (!rst_n)
    exec && accept && is_read && !is_global && !is_group |-> ##2 reply_go) // [R1]
    else $error("direct read not answered two cycles after cr");
  a_foreign_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    exec && !err_r && work_r.addr != own_id_r && !is_global && work_r.addr != group_r
    |=> !cmd_valid) // [R28]
    else $error("command for another address was taken");
  a_chain_first: assert property (@(posedge clk) disable iff (!rst_n)
    exec && accept && is_read && is_global && own_id_r == 8'h01 && !ring_mode
    && !prompted_reply_option |-> ##4 reply_go) // [R8]
    else $error("identifier 01 did not open the chain");
  a_id_clamped: assert property (@(posedge clk) disable iff (!rst_n)
    own_id_r <= mdrop_pkg::ID_MAX) // [R22]
    else $error("unit identifier out of range");
  a_group_range: assert property (@(posedge clk) disable iff (!rst_n)
    group_r >= mdrop_pkg::GROUP_MIN && group_r <= mdrop_pkg::GROUP_MAX) // [R25]
    else $error("group address out of range");
  a_we_needed: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(own_id_r) |-> $past(we_armed_r)) // [R27]
    else $error("identifier changed without write enable");
  a_ring_echo: assert property (@(posedge clk) disable iff (!rst_n)
    ring_mode && exec && is_global |=> echo_req) // [R19]
    else $error("global command not passed back on ring");
  a_header_restart: assert property (@(posedge clk) disable iff (!rst_n)
    f_star |=> state_r == mdrop_pkg::P_ADDR_HI && work_r.ndig == 4'h0) // [R20]
    else $error("new header did not restart parsing");
  a_suspend_ends: assert property (@(posedge clk) disable iff (!rst_n)
    suspend && f_cr |=> !suspend) // [R17]
    else $error("suspend held past carriage return");

  c_group_reply: cover property (@(posedge clk) disable iff (!rst_n) arm_r && is_group ##[1:200] reply_go);
  c_id_assign: cover property (@(posedge clk) disable iff (!rst_n) $changed(own_id_r));
  c_ring_echo: cover property (@(posedge clk) disable iff (!rst_n) echo_req);

endmodule

//--- tb/host_model.sv
/*
  host side of the serial link: frames characters onto the rx strobe.
  assumes the bench calls its tasks and holds clk running.
*/
`timescale 1ns/1ps
module host_model
(
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_char
);
  initial
  begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end
  task automatic put(input logic [7:0] c);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_char = c;
  endtask
  // released char shows the inverse so stale data never looks valid
  task automatic idle();
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_char = ~rx_char;
  endtask
  // header, two address digits, code, closing cr
  task automatic send(input logic [7:0] h, input string b);
    put(h);
    foreach (b[i])
      put(b[i]);
    put(mdrop_pkg::CH_CR);
    idle();
  endtask
  // lone character, e.g. a prompt cr per reply
  task automatic send_char(input logic [7:0] c);
    put(c);
    idle();
  endtask
endmodule

//--- tb/testbench.sv
/*
  self-checking bench for the command interpreter and reply sequencer.
  assumes host_model drives the rx side; outputs are pulse counted.
*/
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, rx_valid, ring, chained, prompted, alt;
  logic [7:0] rx_char, reply_hdr, reply_addr;
  logic cmd_valid, reply_go, suspend, echo_req;
  logic [15:0] group_sub;
  logic [1:0] kind;
  mdrop_pkg::cmd_type cmd;
  int num_errors, compares, n_cmd, n_go, n_echo, dc, dg, de;
  localparam logic [7:0] ST = mdrop_pkg::CH_STAR;

  host_model host_i (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char));
  multidrop_command_addressing multidrop_command_addressing_i (
    .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_char(rx_char),
    .ring_mode(ring), .chained_reply_option(chained),
    .prompted_reply_option(prompted), .alternate_header_select(alt),
    .serial_bcd(32'h00001234), .binary_kind(kind), .cmd_valid(cmd_valid),
    .cmd(cmd), .reply_go(reply_go), .reply_hdr(reply_hdr),
    .reply_addr(reply_addr), .group_sub(group_sub), .suspend(suspend),
    .echo_req(echo_req));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (reply_go === 1'b1) n_go++;
    if (echo_req === 1'b1) n_echo++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // empty body sends a lone cr; host stays quiet while replies run
  task automatic xfer(input logic [7:0] h, input string b);
    int c0, g0, e0;
    c0 = n_cmd;
    g0 = n_go;
    e0 = n_echo;
    if (b == "") host_i.send_char(mdrop_pkg::CH_CR);
    else host_i.send(h, b);
    repeat (10) @(posedge clk);
    #1;
    dc = n_cmd - c0;
    dg = n_go - g0;
    de = n_echo - e0;
  endtask

  task automatic t_reset();
    check("addr", reply_addr, 32'h00);
    check("grp", group_sub, 32'h9000);
    check("susp", suspend, 32'h0);
  endtask
  task automatic t_null();
    xfer(ST, "00s2");
    check("go", dg, 32'h1);
    check("code", cmd.code, 32'h5332);
    check("hdr", reply_hdr, 32'h3f);
    xfer(ST, "99S2");
    check("go", dg, 32'h0);
    xfer(ST, "07S2");
    check("cmd", dc + dg, 32'h0);
  endtask
  task automatic t_assign();
    xfer(ST, "99WE");
    xfer(ST, "99S=00001234");
    xfer(ST, "99WE");
    xfer(ST, "99ID=02");
    check("addr", reply_addr, 32'h02);
    xfer(ST, "02WE");
    xfer(ST, "02ID=9101");
    check("grp", group_sub, 32'h9101);
    check("we", cmd.write_enabled, 32'h1);
    check("val", cmd.value, 32'h00009101);
    xfer(ST, "05S*02S2");
    check("restart", {cmd.addr, 24'(dg)}, 32'h02000001);
    xfer(mdrop_pkg::CH_TILDE, "02P3");
    check("bin", reply_hdr, 32'h40);
    check("tilde", cmd.binary, 32'h1);
    kind = 2'h3;
    repeat (2) @(posedge clk);
    #1;
    check("kind", reply_hdr, 32'h5c);
    xfer(ST, "02S=");
    check("read", cmd.is_read, 32'h1);
  endtask
  task automatic t_chain();
    xfer(ST, "99S2");
    check("wait", dg, 32'h0);
    xfer(ST, "");
    check("go", dg, 32'h1);
    xfer(ST, "91S2");
    check("grp", dg, 32'h1);
    xfer(ST, "90S2");
    check("other", dg, 32'h0);
    xfer(ST, "02WE");
    xfer(ST, "02ID=01");
    xfer(ST, "99S2");
    check("first", dg, 32'h1);
    xfer(ST, "01WE");
    xfer(ST, "01ID=02");
    check("addr", reply_addr, 32'h02);
  endtask
  task automatic t_prompt();
    chained = 1'b0;
    prompted = 1'b1;
    xfer(ST, "99S2");
    xfer(ST, "");
    check("cr1", dg, 32'h0);
    xfer(ST, "");
    check("cr2", dg, 32'h0);
    xfer(ST, "");
    check("cr3", dg, 32'h1);
    chained = 1'b1;
    prompted = 1'b0;
  endtask
  task automatic t_alt();
    alt = 1'b1;
    xfer(mdrop_pkg::ALT_STAR, "02S2");
    check("go", dg, 32'h1);
    check("hdr", reply_hdr, 32'h03);
    xfer(ST, "02S2");
    check("std", dc, 32'h0);
    alt = 1'b0;
  endtask
  task automatic t_ring();
    ring = 1'b1;
    host_i.send_char(mdrop_pkg::CH_DOLLAR);
    repeat (3) @(posedge clk);
    #1;
    check("susp", suspend, 32'h1);
    xfer(ST, "02ABC");
    check("echo", {dc[7:0], de[7:0]}, 32'h0001);
    xfer(ST, "99S2");
    check("echo", de, 32'h1);
    ring = 1'b0;
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #20000;
    num_errors++;
    stop_test();
  end
  initial
  begin
    {rst_n, ring, chained, prompted, alt} = 5'b00100;
    kind = 2'h0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_null();
    t_assign();
    t_chain();
    t_prompt();
    t_alt();
    t_ring();
    stop_test();
  end
endmodule
